// ### hdl/vbrc_top.sv
// Z buffer, three bias correction registers and recording control, over SPI.
// Assumes the signal chain supplies axis samples and capture/stream strobes
// on mclk, and the nonvolatile store presents saved values at reset release.
module vbrc_top
  import vbrc_pkg::*;
#(
  parameter int AN_SAMPLES = AUTONULL_SAMPS,
  parameter int AN_DIV     = SAMPLE_DIV
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  input  wire logic [15:0] x_sample,
  input  wire logic [15:0] y_sample,
  input  wire logic [15:0] z_sample,
  input  wire logic [15:0] combined_sample,
  input  wire logic        capture_done,
  input  wire logic        capture_start,
  input  wire logic        data_ready,
  input  wire logic        autonull_req,
  input  wire logic [15:0] decimation_setting,
  input  wire logic        nv_valid,
  input  wire logic [15:0] nv_xbias,
  input  wire logic [15:0] nv_ybias,
  input  wire logic [15:0] nv_zbias,
  input  wire logic [15:0] nv_rec,
  output logic [15:0]      xbias_out,
  output logic [15:0]      ybias_out,
  output logic [15:0]      zbias_out,
  output logic [1:0]       rec_mode,
  output logic [1:0]       window_sel,
  output logic             combine_en,
  output logic [1:0]       rate_option,
  output logic [3:0]       rate_exponent,
  output logic             stream_halt,
  output logic             autonull_busy
);
  localparam int SH = $clog2(AN_SAMPLES);
  localparam int AW = 16 + SH;

  logic [15:0] rx_word, tx_word;
  logic        rx_valid, sclk_seen;

  vbrc_spi_slave u_spi (
    .mclk      (mclk),
    .resetn    (resetn),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .din       (din),
    .tx_word   (tx_word),
    .rx_word   (rx_word),
    .rx_valid  (rx_valid),
    .sclk_seen (sclk_seen),
    .dout      (dout),
    .dout_oe   (dout_oe)
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [15:0] zbuf_r, zbuf_nxt, xb_r, xb_nxt, yb_r, yb_nxt, zb_r, zb_nxt;
  logic [15:0] rec_r, rec_nxt, rd_r, rd_nxt;
  logic        boot_r, boot_nxt, busy_r, busy_nxt;
  vbrc_an_state_type an_r, an_nxt;
  logic [15:0] div_r, div_nxt;
  logic [SH:0] scnt_r, scnt_nxt;
  logic signed [AW-1:0] ax_r, ax_nxt, ay_r, ay_nxt, az_r, az_nxt;
  logic [2:0]  idle_r, idle_nxt;
  logic        clk_seen_r, clk_seen_nxt, halt_r, halt_nxt;
  logic [1:0]  opt_r, opt_nxt;
  logic [3:0]  exp_r, exp_nxt;

  logic        wr, rd;
  logic [6:0]  addr;
  logic [7:0]  wbyte;
  logic        hi;
  logic [6:0]  base;
  logic        tick;

  function automatic logic [15:0] put_byte(input logic [15:0] cur, input logic high,
                                          input logic [7:0] b);
    put_byte = high ? {b, cur[7:0]} : {cur[15:8], b};
  endfunction

  function automatic logic [15:0] neg_mean(input logic signed [AW-1:0] acc);
    logic signed [AW-1:0] m;
    m        = acc >>> SH;
    neg_mean = 16'(-m[15:0]);
  endfunction

  always_comb begin
    wr    = rx_valid & rx_word[SPI_WR_BIT];
    rd    = rx_valid & ~rx_word[SPI_WR_BIT];
    addr  = rx_word[14:SPI_ADDR_LO];
    wbyte = rx_word[7:0];
    hi    = addr[0];
    base  = {addr[6:1], 1'b0};
    tick  = 1'b0;

    zbuf_nxt = zbuf_r;
    xb_nxt   = xb_r;
    yb_nxt   = yb_r;
    zb_nxt   = zb_r;
    rec_nxt  = rec_r;
    rd_nxt   = rd_r;
    boot_nxt = 1'b0;

    // Host byte writes; each word lands in its own byte lane
    if (wr) begin
      case (base)
        ADDR_ZBUF:  zbuf_nxt = put_byte(zbuf_r, hi, wbyte);
        ADDR_XBIAS: xb_nxt   = put_byte(xb_r, hi, wbyte);
        ADDR_YBIAS: yb_nxt   = put_byte(yb_r, hi, wbyte);
        ADDR_ZBIAS: zb_nxt   = put_byte(zb_r, hi, wbyte);
        ADDR_REC:   rec_nxt  = put_byte(rec_r, hi, wbyte) & REC_MASK;
        default:    ;
      endcase
    end

    // Capture result wins over a host write in the same cycle
    if (capture_done) begin
      // Upstream delivers both in the encoding of the current mode
      zbuf_nxt = rec_r[REC_COMBINE_BIT] ? combined_sample : z_sample;
    end

    // Restore saved copies once, just after reset release
    if (boot_r && nv_valid) begin
      xb_nxt  = nv_xbias;
      yb_nxt  = nv_ybias;
      zb_nxt  = nv_zbias;
      rec_nxt = nv_rec & REC_MASK;
    end

    // Autonull: average a block at full rate, store negated mean
    an_nxt   = an_r;
    div_nxt  = div_r;
    scnt_nxt = scnt_r;
    ax_nxt   = ax_r;
    ay_nxt   = ay_r;
    az_nxt   = az_r;
    case (an_r)
      VBRC_AN_IDLE: begin
        if (autonull_req) begin
          an_nxt   = VBRC_AN_RUN;
          div_nxt  = 16'h0000;
          scnt_nxt = '0;
          ax_nxt   = '0;
          ay_nxt   = '0;
          az_nxt   = '0;
        end
      end
      VBRC_AN_RUN: begin
        tick    = (div_r == 16'(AN_DIV - 1));
        div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
        if (tick) begin
          ax_nxt   = ax_r + AW'(signed'(x_sample));
          ay_nxt   = ay_r + AW'(signed'(y_sample));
          az_nxt   = az_r + AW'(signed'(z_sample));
          scnt_nxt = scnt_r + 1'b1;
          if (scnt_r == (SH + 1)'(AN_SAMPLES - 1)) begin
            an_nxt = VBRC_AN_DONE;
          end
        end
      end
      VBRC_AN_DONE: begin
        // Two's complement offset counts per axis
        xb_nxt = neg_mean(ax_r);
        yb_nxt = neg_mean(ay_r);
        zb_nxt = neg_mean(az_r);
        an_nxt = VBRC_AN_IDLE;
      end
      default: an_nxt = VBRC_AN_IDLE;
    endcase
    busy_nxt = (an_nxt != VBRC_AN_IDLE);

    // Reads answer in the following frame
    if (rd) begin
      case (base)
        ADDR_ZBUF:  rd_nxt = zbuf_r;
        ADDR_XBIAS: rd_nxt = xb_r;
        ADDR_YBIAS: rd_nxt = yb_r;
        ADDR_ZBIAS: rd_nxt = zb_r;
        ADDR_REC:   rd_nxt = rec_r;
        default:    rd_nxt = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Streaming timeout
  // ------------------------------------------------------------
  always_comb begin
    idle_nxt     = idle_r;
    clk_seen_nxt = clk_seen_r | sclk_seen;
    halt_nxt     = 1'b0;
    if (!(rec_r[REC_TIMEOUT_BIT] && rec_r[REC_MODE_LO +: 2] == VBRC_MODE_STREAM)) begin
      idle_nxt     = 3'h0;
      clk_seen_nxt = 1'b0;
    end else if (data_ready) begin
      // A clock edge in the closing cycle still counts as collected
      clk_seen_nxt = 1'b0;
      if (clk_seen_r || sclk_seen) begin
        idle_nxt = 3'h0;
      end else if (idle_r == 3'(STREAM_IDLE_PERIODS - 1)) begin
        idle_nxt = 3'h0;
        halt_nxt = 1'b1;
      end else begin
        idle_nxt = idle_r + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Rate option rotation
  // ------------------------------------------------------------
  always_comb begin
    logic [1:0] cand;
    cand    = opt_r;
    opt_nxt = opt_r;
    if (capture_start) begin
      // Next enabled option above the current one, wrapping round
      for (int i = 1; i <= 4; i++) begin
        cand = 2'(opt_r + 2'(i));
        if (rec_r[REC_RATE_LO + cand] && opt_nxt == opt_r) begin
          opt_nxt = cand;
        end
      end
    end
    exp_nxt = decimation_setting[4*opt_nxt +: 4];
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      zbuf_r     <= ZBUF_RST;
      xb_r       <= BIAS_RST;
      yb_r       <= BIAS_RST;
      zb_r       <= BIAS_RST;
      rec_r      <= REC_RST;
      rd_r       <= 16'h0000;
      boot_r     <= 1'b1;
      an_r       <= VBRC_AN_IDLE;
      busy_r     <= 1'b0;
      div_r      <= 16'h0000;
      scnt_r     <= '0;
      ax_r       <= '0;
      ay_r       <= '0;
      az_r       <= '0;
      idle_r     <= 3'h0;
      clk_seen_r <= 1'b0;
      halt_r     <= 1'b0;
      opt_r      <= 2'h0;
      exp_r      <= 4'h0;
    end else begin
      zbuf_r     <= zbuf_nxt;
      xb_r       <= xb_nxt;
      yb_r       <= yb_nxt;
      zb_r       <= zb_nxt;
      rec_r      <= rec_nxt;
      rd_r       <= rd_nxt;
      boot_r     <= boot_nxt;
      an_r       <= an_nxt;
      busy_r     <= busy_nxt;
      div_r      <= div_nxt;
      scnt_r     <= scnt_nxt;
      ax_r       <= ax_nxt;
      ay_r       <= ay_nxt;
      az_r       <= az_nxt;
      idle_r     <= idle_nxt;
      clk_seen_r <= clk_seen_nxt;
      halt_r     <= halt_nxt;
      opt_r      <= opt_nxt;
      exp_r      <= exp_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign tx_word       = rd_r;
  assign xbias_out     = xb_r;
  assign ybias_out     = yb_r;
  assign zbias_out     = zb_r;
  assign rec_mode      = rec_r[REC_MODE_LO +: 2];
  assign window_sel    = rec_r[REC_WIN_LO +: 2];
  assign combine_en    = rec_r[REC_COMBINE_BIT];
  assign rate_option   = opt_r;
  assign rate_exponent = exp_r;
  assign stream_halt   = halt_r;
  assign autonull_busy = busy_r;
endmodule

// ### common/vbrc_pkg.sv
// Constants shared by the vibration bias and recording configuration block.
// Assumes a 200 MHz mclk and a host that speaks 16-bit SPI words, mode 3.
package vbrc_pkg;
  // ------------------------------------------------------------
  // Register byte addresses (low byte of each 16-bit register)
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_ZBUF  = 7'h12;
  localparam logic [6:0] ADDR_XBIAS = 7'h14;
  localparam logic [6:0] ADDR_YBIAS = 7'h16;
  localparam logic [6:0] ADDR_ZBIAS = 7'h18;
  localparam logic [6:0] ADDR_REC   = 7'h1a;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] ZBUF_RST = 16'h0000;
  localparam logic [15:0] BIAS_RST = 16'h0000;
  localparam logic [15:0] REC_RST  = 16'h1102;
  localparam logic [15:0] REC_MASK = 16'hbfff;

  // ------------------------------------------------------------
  // Recording control fields
  // ------------------------------------------------------------
  localparam int REC_TIMEOUT_BIT = 15;
  localparam int REC_WIN_LO      = 12;
  localparam int REC_RATE_LO     = 8;
  localparam int REC_COMBINE_BIT = 4;
  localparam int REC_MODE_LO     = 0;

  typedef enum logic [1:0] {
    VBRC_MODE_MANUAL_FFT = 2'h0,
    VBRC_MODE_AUTO_FFT   = 2'h1,
    VBRC_MODE_TIME_CAPT  = 2'h2,
    VBRC_MODE_STREAM     = 2'h3
  } vbrc_mode_type;

  typedef enum logic [1:0] {
    VBRC_WIN_RECT    = 2'h0,
    VBRC_WIN_HANNING = 2'h1,
    VBRC_WIN_FLATTOP = 2'h2,
    VBRC_WIN_NONE    = 2'h3
  } vbrc_window_type;

  // ------------------------------------------------------------
  // Serial word layout
  // ------------------------------------------------------------
  localparam int SPI_WORD_BITS = 16;
  localparam int SPI_WR_BIT    = 15;
  localparam int SPI_ADDR_LO   = 8;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 200_000_000;
  localparam int FULL_RATE_HZ    = 220_000;
  localparam int SAMPLE_DIV      = CLK_HZ / FULL_RATE_HZ;
  localparam int AUTONULL_SAMPS  = 4096;
  localparam int AUTONULL_TIME_MS = 16;
  localparam int STREAM_IDLE_PERIODS = 5;

  typedef enum logic [1:0] {
    VBRC_AN_IDLE = 2'b00,
    VBRC_AN_RUN  = 2'b01,
    VBRC_AN_DONE = 2'b11
  } vbrc_an_state_type;
endpackage

// ### hdl/vbrc_spi_slave.sv
// SPI slave, mode 3, 16-bit words, oversampled on mclk.
// Assumes sclk well below mclk / 8 so every edge is seen after synchronising.
module vbrc_spi_slave
  import vbrc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic [15:0] tx_word,
  output logic      [15:0] rx_word,
  output logic             rx_valid,
  output logic             sclk_seen,
  output logic             dout,
  output logic             dout_oe
);
  logic [2:0]  sclk_r, sclk_nxt;
  logic [2:0]  cs_r, cs_nxt;
  logic [1:0]  din_r, din_nxt;
  logic [15:0] rx_r, rx_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [15:0] word_r, word_nxt;
  logic        valid_r, valid_nxt;
  logic        seen_r, seen_nxt;
  logic        dout_r, dout_nxt;
  logic        oe_r, oe_nxt;
  logic        rise, fall, cs_fall, active;

  always_comb begin
    sclk_nxt  = {sclk_r[1:0], sclk};
    cs_nxt    = {cs_r[1:0], cs_n};
    din_nxt   = {din_r[0], din};
    // Edges from stages 1 and 2 only; stage 0 feeds nothing but stage 1
    rise      = sclk_r[1] & ~sclk_r[2];
    fall      = ~sclk_r[1] & sclk_r[2];
    cs_fall   = ~cs_r[1] & cs_r[2];
    active    = ~cs_r[1];
    rx_nxt    = rx_r;
    tx_nxt    = tx_r;
    cnt_nxt   = cnt_r;
    word_nxt  = word_r;
    valid_nxt = 1'b0;
    seen_nxt  = active & rise;
    if (cs_fall) begin
      tx_nxt  = tx_word;
      cnt_nxt = 5'h00;
    end else if (active & fall & (cnt_r != 5'h00)) begin
      // Leading fall of a frame keeps the preloaded MSB on the line
      tx_nxt = {tx_r[14:0], 1'b0};
    end
    if (active & rise & ~cs_fall) begin
      rx_nxt  = {rx_r[14:0], din_r[1]};
      cnt_nxt = cnt_r + 5'h01;
      if (cnt_r == 5'(SPI_WORD_BITS - 1)) begin
        word_nxt  = {rx_r[14:0], din_r[1]};
        valid_nxt = 1'b1;
        cnt_nxt   = 5'h00;
      end
    end
    dout_nxt = active & tx_nxt[15];
    oe_nxt   = active;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sclk_r  <= 3'h7;
      cs_r    <= 3'h7;
      din_r   <= 2'h0;
      rx_r    <= 16'h0000;
      tx_r    <= 16'h0000;
      cnt_r   <= 5'h00;
      word_r  <= 16'h0000;
      valid_r <= 1'b0;
      seen_r  <= 1'b0;
      dout_r  <= 1'b0;
      oe_r    <= 1'b0;
    end else begin
      sclk_r  <= sclk_nxt;
      cs_r    <= cs_nxt;
      din_r   <= din_nxt;
      rx_r    <= rx_nxt;
      tx_r    <= tx_nxt;
      cnt_r   <= cnt_nxt;
      word_r  <= word_nxt;
      valid_r <= valid_nxt;
      seen_r  <= seen_nxt;
      dout_r  <= dout_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign rx_word   = word_r;
  assign rx_valid  = valid_r;
  assign sclk_seen = seen_r;
  assign dout      = dout_r;
  assign dout_oe   = oe_r;
endmodule

// ### verif/vbrc_properties.sv
// Port checker for vbrc_top.
// Assumes a bind onto vbrc_top; sees only its ports.
module vbrc_properties
  import vbrc_pkg::*;
#(
  parameter int AN_SAMPLES = AUTONULL_SAMPS,
  parameter int AN_DIV     = SAMPLE_DIV
) (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        cs_n,
  input wire logic        capture_start,
  input wire logic        data_ready,
  input wire logic        autonull_req,
  input wire logic [15:0] decimation_setting,
  input wire logic        nv_valid,
  input wire logic [15:0] nv_xbias,
  input wire logic [15:0] nv_ybias,
  input wire logic [15:0] xbias_out,
  input wire logic [15:0] ybias_out,
  input wire logic [1:0]  rec_mode,
  input wire logic [1:0]  window_sel,
  input wire logic [1:0]  rate_option,
  input wire logic [3:0]  rate_exponent,
  input wire logic        stream_halt,
  input wire logic        autonull_busy
);
  // Busy lasts AN_SAMPLES * AN_DIV + 1 cycles; the lower bound leaves one divider of slack
  localparam int AN_MIN = (AN_SAMPLES - 1) * AN_DIV;
  localparam int AN_MAX = AN_SAMPLES * AN_DIV + 4;
  logic [31:0] busy_cnt_r;
  logic [3:0]  cs_idle_r;
  logic [15:0] dec_d_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_cnt_r <= 32'h0;
      cs_idle_r  <= 4'hf;
      dec_d_r    <= 16'h0000;
    end else begin
      busy_cnt_r <= autonull_busy ? busy_cnt_r + 32'h1 : 32'h0;
      cs_idle_r  <= !cs_n ? 4'h0 : ((cs_idle_r == 4'hf) ? cs_idle_r : cs_idle_r + 4'h1);
      dec_d_r    <= decimation_setting;
    end
  end

  // --------------------------------------------------------
  // Assertions
  // --------------------------------------------------------
  AST_RESET_VALUES: assert property (
    $rose(resetn) |-> xbias_out == 16'h0000 && rec_mode == 2'h2 && window_sel == 2'h1)
    else $error("outputs differ from reset values after release");
  AST_NV_RESTORE: assert property (
    $rose(resetn) && nv_valid |=> xbias_out == $past(nv_xbias) && ybias_out == $past(nv_ybias))
    else $error("saved bias values not restored");
  AST_AN_START: assert property (
    autonull_req && !autonull_busy |=> autonull_busy)
    else $error("autonull request not taken");
  AST_AN_LENGTH: assert property (
    $fell(autonull_busy) && $past(resetn) |->
      busy_cnt_r >= 32'(AN_MIN) && busy_cnt_r <= 32'(AN_MAX))
    else $error("autonull length out of range");
  AST_BIAS_SOURCE: assert property (
    !$stable(xbias_out) |->
      autonull_busy || $past(autonull_busy) || cs_idle_r < 4'hc || !$past(resetn, 2))
    else $error("bias changed without autonull or host write");
  AST_HALT_PULSE: assert property (
    stream_halt |=> !stream_halt)
    else $error("halt pulse longer than one cycle");
  AST_HALT_CAUSE: assert property (
    stream_halt |-> rec_mode == 2'h3 && ($past(data_ready) || $past(data_ready, 2)))
    else $error("halt without streaming data-ready period");
  AST_RATE_HOLD: assert property (
    !$stable(rate_option) |-> $past(capture_start) || !$past(resetn, 2))
    else $error("rate option moved without capture start");
  AST_RATE_EXP: assert property (
    rate_exponent == dec_d_r[{rate_option, 2'b00} +: 4])
    else $error("rate exponent not the selected decimation field");

  COV_AUTONULL: cover property ($fell(autonull_busy));
  COV_HALT: cover property (stream_halt);
  COV_ROTATE: cover property (!$stable(rate_option));
endmodule

bind vbrc_top vbrc_properties #(.AN_SAMPLES(AN_SAMPLES), .AN_DIV(AN_DIV)) vbrc_properties_i (.*);

// ### verif/vbrc_host_model.sv
// Host on the serial register link: mode 3, 16-bit words, MSB first.
// Assumes the device answers a read word in the following frame.
module vbrc_host_model (
  input  wire logic mclk,
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe
);
  int   hp     = 5;
  logic last_r = 1'b0;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b1;
  end
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    cs_n <= 1'b0;
    repeat (6) @(posedge mclk);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      din  <= w[i];
      repeat (hp) @(posedge mclk);
      // Undriven line reads as the inverse of the last bit
      r[i]   = dout_oe ? dout : ~last_r;
      last_r = r[i];
      sclk <= 1'b1;
      repeat (hp) @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
    cs_n <= 1'b1;
    din  <= ~w[0];
    repeat (6) @(posedge mclk);
  endtask
  // Low byte first, each byte its own write word
  task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    frame({1'b1, a, d[7:0]}, r);
    frame({1'b1, a | 7'h01, d[15:8]}, r);
  endtask
  task automatic read_reg(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] r;
    frame({1'b0, a, 8'h00}, r);
    frame(16'h0000, d);
  endtask
endmodule

// ### verif/vbrc_top_tb.sv
// Self-checking bench for vbrc_top; host model on the serial link.
// Assumes shortened autonull counts; all other figures are the block's own.
module vbrc_top_tb
  import vbrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AN_N = 16;
  localparam int AN_D = 2;
  logic        mclk = 1'b0;
  logic        resetn, capture_done, capture_start, data_ready, autonull_req, nv_valid;
  logic [15:0] x_sample, y_sample, z_sample, combined_sample, decimation_setting;
  logic [15:0] nv_xbias, nv_ybias, nv_zbias, nv_rec, xbias_out, ybias_out, zbias_out;
  logic        sclk, cs_n, din, dout, dout_oe, combine_en, stream_halt, autonull_busy;
  logic [1:0]  rec_mode, window_sel, rate_option;
  logic [3:0]  rate_exponent;
  int          failures, check_count, cyc, halt_cnt;

  always #2.5 mclk = ~mclk;
  vbrc_top #(.AN_SAMPLES(AN_N), .AN_DIV(AN_D)) vbrc_top_i (.*);
  vbrc_host_model vbrc_host_model_i (.*);

  // --------------------------------------------------------
  // Helpers
  // --------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    vbrc_host_model_i.write_reg(a, d);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    vbrc_host_model_i.read_reg(a, d);
  endtask
  // Next enabled option above cur, wrapping; none enabled keeps cur
  function automatic logic [1:0] next_opt(input logic [1:0] cur, input logic [3:0] m);
    next_opt = cur;
    for (int k = 4; k >= 1; k--) begin
      logic [1:0] c;
      c = cur + 2'(k);
      if (m[c]) next_opt = c;
    end
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (stream_halt === 1'b1) halt_cnt++;
    if (cyc == 60000) begin
      failures++;
      $display("ERROR timeout expected finish seen %0d cycles", cyc);
      tally_and_finish();
    end
  end

  // --------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------
  initial begin
    logic [15:0] rv;
    logic [15:0] v;
    logic [15:0] s [3];
    logic [3:0]  m;
    logic [1:0]  om;
    logic [6:0]  ad [4];
    {resetn, capture_done, capture_start, data_ready, autonull_req, nv_valid} = 6'h00;
    {x_sample, y_sample, z_sample, combined_sample, decimation_setting} = 80'h0;
    {nv_xbias, nv_ybias, nv_zbias, nv_rec} = 64'h0;
    ad = '{ADDR_XBIAS, ADDR_YBIAS, ADDR_ZBIAS, ADDR_ZBUF};
    void'($urandom(32'hb1dcbc5a));
    clk(10);
    resetn <= 1'b1;
    clk(3);
    for (int i = 0; i < 4; i++) begin
      rd(ad[i], rv);
      chk("reset value", 16'h0000, rv);
    end
    rd(ADDR_REC, rv);
    chk("rec reset", REC_RST, rv);
    rd(7'h20, rv);
    chk("unmapped read", 16'h0000, rv);
    $display("test reset done");
    s = '{16'h0064, 16'hff9c, 16'hfdde};
    for (int r = 0; r < 3; r++) begin
      vbrc_host_model_i.hp = 5 + 4 * r;
      for (int i = 0; i < 3; i++) begin
        v = (r == 0) ? s[i] : ((r == 1) ? {i[0], {15{~i[0]}}} : 16'($urandom));
        wr(ad[i], v);
        rd(ad[i], rv);
        chk("bias readback", v, rv);
        rv = (i == 0) ? xbias_out : ((i == 1) ? ybias_out : zbias_out);
        chk("bias port", v, rv);
      end
    end
    vbrc_host_model_i.hp = 5;
    $display("test bias done");
    for (int w = 0; w < 4; w++) begin
      v = {2'b11, 2'(w), 12'($urandom)};
      wr(ADDR_REC, v);
      rd(ADDR_REC, rv);
      chk("rec readback", v & REC_MASK, rv);
      chk("window", 16'(w), 16'(window_sel));
      chk("mode", 16'(v[1:0]), 16'(rec_mode));
      chk("combine", 16'(v[4]), 16'(combine_en));
    end
    $display("test control done");
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_REC, 16'h1100 | 16'((k % 2) << 4) | 16'(k / 2));
      z_sample <= 16'($urandom);
      combined_sample <= (k == 7) ? 16'h8000 : 16'($urandom);
      clk(1);
      capture_done <= 1'b1;
      clk(1);
      capture_done <= 1'b0;
      rd(ADDR_ZBUF, rv);
      chk("z buffer", (k % 2 == 1) ? combined_sample : z_sample, rv);
    end
    $display("test z buffer done");
    om = 2'h0;
    for (int t = 0; t < 3; t++) begin
      m = (t == 0) ? 4'hf : ((t == 1) ? 4'h5 : 4'($urandom));
      wr(ADDR_REC, {4'h1, m, 8'h02});
      for (int c = 0; c < 6; c++) begin
        decimation_setting <= 16'($urandom);
        capture_start <= 1'b1;
        clk(1);
        capture_start <= 1'b0;
        om = next_opt(om, m);
        clk(3);
        chk("rate option", 16'(om), 16'(rate_option));
        v = 16'(decimation_setting[{om, 2'b00} +: 4]);
        chk("rate exponent", v, 16'(rate_exponent));
      end
    end
    $display("test rate options done");
    // Case 0 timeout off, 1 idle host, 2 host clocks mid-way
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_REC, (c == 0) ? 16'h1103 : 16'h9103);
      halt_cnt = 0;
      for (int p = 0; p < 8; p++) begin
        if (c == 2 && p == 4) rd(ADDR_REC, rv);
        data_ready <= 1'b1;
        clk(1);
        data_ready <= 1'b0;
        clk(20);
      end
      chk("halt pulses", (c == 1) ? 16'h1 : 16'h0, 16'(halt_cnt));
    end
    $display("test timeout done");
    for (int i = 0; i < 3; i++) s[i] = 16'($urandom_range(2000)) - 16'h03e8;
    x_sample <= s[0];
    y_sample <= s[1];
    z_sample <= s[2];
    clk(1);
    autonull_req <= 1'b1;
    clk(1);
    autonull_req <= 1'b0;
    clk(1);
    chk("autonull busy", 16'h1, 16'(autonull_busy));
    for (int w = 0; w < 1000 && autonull_busy !== 1'b0; w++) clk(1);
    chk("x autonull", -s[0], xbias_out);
    chk("y autonull", -s[1], ybias_out);
    rd(ADDR_ZBIAS, rv);
    chk("z autonull", -s[2], rv);
    $display("test autonull done");
    resetn <= 1'b0;
    nv_valid <= 1'b1;
    nv_xbias <= 16'($urandom);
    nv_ybias <= 16'($urandom);
    nv_zbias <= 16'($urandom);
    nv_rec <= 16'($urandom) | 16'h4000;
    clk(10);
    resetn <= 1'b1;
    clk(3);
    chk("x restore", nv_xbias, xbias_out);
    chk("z restore", nv_zbias, zbias_out);
    rd(ADDR_REC, rv);
    chk("rec restore", nv_rec & REC_MASK, rv);
    $display("test restore done");
    tally_and_finish();
  end
endmodule
